// File: core/civ_arbiter.sv
// Fixed priority arbiter, lower source number wins
`timescale 1ns/1ps
module civ_arbiter #(
    parameter int NSRC = 8
) (
    input  wire logic [NSRC-1:0] req_i,   // Enabled requests
    output logic                 any_o,   // Any request
    output logic [2:0]           idx_o    // Winning index
);
    always_comb begin
        any_o = 1'b0;
        idx_o = 3'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                idx_o = 3'(i);
            end
        end
    end
endmodule

// File: core/civ_ctrl.sv
// Interrupt acceptance, entry and return sequencing for the CPU core
`timescale 1ns/1ps
`include "civ_map.svh"

module civ_ctrl
    import civ_pkg::*;
#(
    parameter int          NSRC       = `CIV_NSRC,
    parameter logic [14:0] BOOT_START = `CIV_BOOT_START
) (
    input  wire logic              clk_i,         // CPU clock
    input  wire logic              rst_b_i,       // Sync reset, low
    input  wire logic [NSRC-1:0]   event_i,       // Flag-type event pulses
    input  wire logic [NSRC-1:0]   level_i,       // Level-type conditions
    input  wire logic [NSRC-1:0]   is_level_i,    // Source is level type
    input  wire logic [NSRC-1:0]   src_enable_i,  // Per-source enables
    input  wire logic [NSRC-1:0]   flag_wr_i,     // Flag write strobe
    input  wire logic [NSRC-1:0]   flag_wdata_i,  // Flag write data
    input  wire logic              status_reg_wr_i,     // Status write strobe
    input  wire logic [7:0]        status_reg_wdata_i,  // Status write data
    input  wire logic              boundary_i,    // Instruction boundary
    input  wire civ_op_t           op_i,          // Retiring instruction
    input  wire logic              sleeping_i,    // Core is asleep
    input  wire logic              vector_table_select_i,   // Relocate
    input  wire logic              reset_vector_boot_fuse_i,// Boot reset
    input  wire logic              app_section_lock_bit_i,  // App lock
    input  wire logic              boot_section_lock_bit_i, // Boot lock
    input  wire logic [14:0]       pc_i,          // Current PC
    input  wire logic [14:0]       ret_pc_i,      // Popped return PC
    output logic [NSRC-1:0]        flags_o,       // Pending flags
    output logic [7:0]             status_reg_o,  // Status register
    output logic [15:0]            sp_o,          // Stack pointer
    output logic [14:0]            reset_vec_o,   // Reset vector
    output logic                   stall_o,       // Hold the sequencer
    output civ_stack_t             stack_o,       // Push or pop strobe
    output logic                   pc_load_o,     // Load new PC
    output logic [14:0]            pc_load_val_o, // New PC value
    output logic [2:0]             active_src_o,  // Source being entered
    output logic                   in_entry_o     // Entry, wake or return in progress
);
    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAKE,
        ST_ENTRY,
        ST_RETURN_FROM_HANDLER_OP
    } civ_state_t;

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    civ_state_t      state_reg,  state_next;
    logic [2:0]      cnt_reg,    cnt_next;
    logic [NSRC-1:0] flag_reg,   flag_next;
    logic [7:0]      status_reg_reg,   status_reg_next;
    logic [15:0]     sp_reg,     sp_next;
    logic            hold_reg,   hold_next;
    logic [2:0]      src_reg,    src_next;
    logic [14:0]     vec_reg,    vec_next;
    logic            pcld_reg,   pcld_next;
    logic [14:0]     pcv_reg,    pcv_next;
    civ_stack_t      stk_reg,    stk_next;

    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] enabled_req;
    logic            any_req;
    logic [2:0]      win_idx;
    logic [14:0]     irq_vec;
    logic            gie;
    logic            lock_block;
    logic            take;

    function automatic logic in_boot(input logic [14:0] pc);
        in_boot = (pc >= BOOT_START);
    endfunction

    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            // Level sources are never latched, so a vanished condition
            // leaves nothing behind to be served later
            pending[i] = is_level_i[i] ? level_i[i] : flag_reg[i];
        end
        gie = status_reg_reg[`CIV_GIE_BIT];
        // Code running in a locked section may not be interrupted
        lock_block = (app_section_lock_bit_i && !in_boot(pc_i)) ||
                     (boot_section_lock_bit_i && in_boot(pc_i));
        enabled_req = pending & src_enable_i;
    end

    civ_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .req_i (enabled_req),
        .any_o (any_req),
        .idx_o (win_idx)
    );

    civ_vector_gen u_vec (
        .vec_sel_i   (vector_table_select_i),
        .rst_fuse_i  (reset_vector_boot_fuse_i),
        .boot_base_i (BOOT_START),
        .src_i       (win_idx),
        .reset_vec_o (reset_vec_o),
        .irq_vec_o   (irq_vec)
    );

    // A request is accepted only at a boundary, never right after an
    // enable or return, and never on the cycle a disable retires
    always_comb begin
        take = (state_reg == ST_RUN) && boundary_i && any_req && gie &&
               !hold_reg && !lock_block && (op_i != CIV_OP_CLI) &&
               (op_i != CIV_OP_SEI) && (op_i != CIV_OP_RETURN_FROM_HANDLER_OP);
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        flag_next  = flag_reg;
        status_reg_next  = status_reg_reg;
        sp_next    = sp_reg;
        hold_next  = hold_reg;
        src_next   = src_reg;
        vec_next   = vec_reg;
        pcld_next  = 1'b0;
        pcv_next   = pcv_reg;
        stk_next   = '0;

        if (boundary_i && state_reg == ST_RUN && op_i == CIV_OP_NONE) begin
            hold_next = 1'b0;
        end

        // Status writes carry every bit; nothing is saved on entry
        if (status_reg_wr_i) begin
            status_reg_next = status_reg_wdata_i;
        end
        if (state_reg == ST_RUN && boundary_i) begin
            case (op_i)
                CIV_OP_SEI: begin
                    status_reg_next[`CIV_GIE_BIT] = 1'b1;
                    hold_next = 1'b1;
                end
                CIV_OP_CLI: begin
                    status_reg_next[`CIV_GIE_BIT] = 1'b0;
                end
                CIV_OP_RETURN_FROM_HANDLER_OP: begin
                    state_next = ST_RETURN_FROM_HANDLER_OP;
                    // Boundary cycle counts as the first of the four
                    cnt_next   = 3'(`CIV_RETURN_FROM_HANDLER_OP_CYC - 2);
                    stk_next.pop = 1'b1;
                end
                default: begin
                end
            endcase
        end

        case (state_reg)
            ST_RUN: begin
                if (take) begin
                    src_next = win_idx;
                    vec_next = irq_vec;
                    status_reg_next[`CIV_GIE_BIT] = 1'b0;
                    if (!is_level_i[win_idx]) begin
                        flag_next[win_idx] = 1'b0;
                    end
                    if (sleeping_i) begin
                        state_next = ST_WAKE;
                        cnt_next   = 3'(`CIV_WAKE_CYC - 1);
                    end else begin
                        state_next = ST_ENTRY;
                        // Take cycle counts as the first of the four
                        cnt_next   = 3'(`CIV_ENTRY_CYC - 2);
                        stk_next.push = 1'b1;
                        stk_next.addr = pc_i;
                        sp_next = sp_reg - `CIV_SP_STEP;
                    end
                end
            end
            ST_WAKE: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0) begin
                    state_next = ST_ENTRY;
                    cnt_next   = 3'(`CIV_ENTRY_CYC - 2);
                    stk_next.push = 1'b1;
                    stk_next.addr = pc_i;
                    sp_next = sp_reg - `CIV_SP_STEP;
                end
            end
            ST_ENTRY: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    pcld_next = 1'b1;
                    pcv_next  = vec_reg;
                end
                if (cnt_reg == 3'h0) begin
                    state_next = ST_RUN;
                end
            end
            ST_RETURN_FROM_HANDLER_OP: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    sp_next   = sp_reg + `CIV_SP_STEP;
                    pcld_next = 1'b1;
                    pcv_next  = ret_pc_i;
                    status_reg_next[`CIV_GIE_BIT] = 1'b1;
                end
                if (cnt_reg == 3'h0) begin
                    state_next = ST_RUN;
                    hold_next  = 1'b1;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase

        // Software clears by writing one; a new event wins the same cycle
        for (int i = 0; i < NSRC; i++) begin
            if (flag_wr_i[i] && flag_wdata_i[i]) begin
                flag_next[i] = 1'b0;
            end
            if (event_i[i] && !is_level_i[i]) begin
                flag_next[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_RUN;
            cnt_reg   <= 3'h0;
            flag_reg  <= '0;
            status_reg_reg  <= `CIV_STATUS_REG_RST;
            sp_reg    <= `CIV_SP_RST;
            hold_reg  <= 1'b0;
            src_reg   <= 3'h0;
            vec_reg   <= 15'h0000;
            pcld_reg  <= 1'b0;
            pcv_reg   <= 15'h0000;
            stk_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            flag_reg  <= flag_next;
            status_reg_reg  <= status_reg_next;
            sp_reg    <= sp_next;
            hold_reg  <= hold_next;
            src_reg   <= src_next;
            vec_reg   <= vec_next;
            pcld_reg  <= pcld_next;
            pcv_reg   <= pcv_next;
            stk_reg   <= stk_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        flags_o       = flag_reg;
        status_reg_o  = status_reg_reg;
        sp_o          = sp_reg;
        stack_o       = stk_reg;
        pc_load_o     = pcld_reg;
        pc_load_val_o = pcv_reg;
        active_src_o  = src_reg;
        in_entry_o    = (state_reg != ST_RUN);
        stall_o       = (state_reg != ST_RUN) || take;
    end
endmodule

// File: core/civ_map.svh
// Constants for the interrupt vectoring block
`ifndef CIV_MAP_SVH
`define CIV_MAP_SVH
`define CIV_PC_W        15
`define CIV_SP_W        16
`define CIV_NSRC        8
`define CIV_GIE_BIT     7
`define CIV_VEC_STRIDE  2
`define CIV_ENTRY_CYC   4
`define CIV_WAKE_CYC    4
`define CIV_JMP_CYC     3
`define CIV_RETURN_FROM_HANDLER_OP_CYC    4
`define CIV_SP_STEP     16'h0002
`define CIV_SP_RST      16'h0000
`define CIV_STATUS_REG_RST    8'h00
`define CIV_BOOT_START  15'h7000
`endif

// File: core/civ_pkg.sv
// Types for the interrupt vectoring block
package civ_pkg;
    typedef enum logic [1:0] {
        CIV_OP_NONE,
        CIV_OP_SEI,
        CIV_OP_CLI,
        CIV_OP_RETURN_FROM_HANDLER_OP
    } civ_op_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  src;
        logic [14:0] vector;
    } civ_grant_t;

    typedef struct packed {
        logic        push;
        logic        pop;
        logic [14:0] addr;
    } civ_stack_t;
endpackage

// File: core/civ_vector_gen.sv
// Vector address generation for reset and interrupt sources
`timescale 1ns/1ps
`include "civ_map.svh"
module civ_vector_gen (
    input  wire logic        vec_sel_i,  // Vector table relocated
    input  wire logic        rst_fuse_i, // Reset vector in boot area
    input  wire logic [14:0] boot_base_i,// Boot section start
    input  wire logic [2:0]  src_i,      // Source index
    output logic      [14:0] reset_vec_o,// Reset vector
    output logic      [14:0] irq_vec_o   // Interrupt vector
);
    logic [14:0] base;
    always_comb begin
        base        = vec_sel_i ? boot_base_i : 15'h0000;
        reset_vec_o = rst_fuse_i ? boot_base_i : 15'h0000;
        // Slot zero is reset, so source n sits at slot n+1
        irq_vec_o   = base + 15'((32'(src_i) + 1) * `CIV_VEC_STRIDE);
    end
endmodule

// File: tb/civ_cpu_model.sv
// Sequencer side model: program counter and return address stack
`timescale 1ns/1ps
module civ_cpu_model
    import civ_pkg::*;
(
    input  wire logic        clk_i,         // CPU clock
    input  wire logic        rst_b_i,       // Sync reset, low
    input  wire logic        boundary_i,    // Instruction retires
    input  wire logic        stall_i,       // Sequencer held
    input  wire civ_stack_t  stack_i,       // Push or pop strobe
    input  wire logic        pc_load_i,     // Load new PC
    input  wire logic [14:0] pc_load_val_i, // New PC value
    output logic      [14:0] pc_o,          // Current PC
    output logic      [14:0] ret_pc_o       // Top of stack
);
    logic [14:0] mem [0:7];
    logic [2:0]  dep;
    logic        pend;
    // Empty stack shows a pattern so a stray pop never looks valid
    assign ret_pc_o = (dep == 3'h0) ? 15'h5555 : mem[dep - 3'h1];
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pc_o <= 15'h0000;
            dep <= 3'h0;
            pend <= 1'b0;
        end else begin
            if (pc_load_i)
                pc_o <= pc_load_val_i;
            else if (boundary_i && !stall_i)
                pc_o <= pc_o + 15'h0001;
            if (stack_i.push)
                mem[dep] <= stack_i.addr;
            if (stack_i.push)
                dep <= dep + 3'h1;
            // Word stays on top until the return load has used it
            if (pc_load_i && pend)
                dep <= dep - 3'h1;
            pend <= stack_i.pop | (pend & ~pc_load_i);
        end
    end
endmodule

// File: tb/civ_ctrl_props.sv
// Assertion checker for the interrupt vectoring control
`timescale 1ns/1ps
module civ_ctrl_props
    import civ_pkg::*;
#(
    parameter int          NSRC       = 8,
    parameter logic [14:0] BOOT_START = 15'h7000
) (
    input wire logic            clk_i,                    // CPU clock
    input wire logic            rst_b_i,                  // Sync reset, low
    input wire logic            boundary_i,               // Boundary
    input wire civ_op_t         op_i,                     // Retiring op
    input wire logic            vector_table_select_i,    // Relocate
    input wire logic            reset_vector_boot_fuse_i, // Boot reset
    input wire logic [14:0]     pc_i,                     // Current PC
    input wire logic [14:0]     ret_pc_i,                 // Popped PC
    input wire logic [NSRC-1:0] flags_o,                  // Pending flags
    input wire logic [7:0]      status_reg_o,             // Status
    input wire logic [15:0]     sp_o,                     // Stack pointer
    input wire logic [14:0]     reset_vec_o,              // Reset vector
    input wire civ_stack_t      stack_o,                  // Stack strobes
    input wire logic            pc_load_o,                // Load PC
    input wire logic [14:0]     pc_load_val_o,            // New PC
    input wire logic [2:0]      active_src_o,             // Source
    input wire logic            in_entry_o                // Sequencing
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [14:0] base;
    assign base = vector_table_select_i ? BOOT_START : 15'h0000;
    sequence s_push;
        stack_o.push ##2 pc_load_o;
    endsequence
    sequence s_pop;
        stack_o.pop ##2 pc_load_o;
    endsequence

    a_entry_timing: assert property (stack_o.push |-> s_push)
        else $error("vector load not two cycles after push");
    a_entry_vector: assert property (s_push |-> pc_load_val_o ==
        base + {11'h000, active_src_o, 1'b0} + 15'h0002)
        else $error("wrong interrupt vector");
    a_push_state: assert property (stack_o.push |-> !status_reg_o[7] &&
        sp_o == $past(sp_o) - 16'h0002 && stack_o.addr == $past(pc_i))
        else $error("bad state at push");
    a_flag_cleared: assert property (stack_o.push |-> !flags_o[active_src_o])
        else $error("flag of entered source still set");
    a_return_seq: assert property (stack_o.pop |-> s_pop ##0
        (pc_load_val_o == ret_pc_i && status_reg_o[7] &&
        sp_o == $past(sp_o, 2) + 16'h0002))
        else $error("bad return sequence");
    a_cli_blocks: assert property (boundary_i && op_i == CIV_OP_CLI &&
        !in_entry_o |-> ##1 (!stack_o.push && !status_reg_o[7]))
        else $error("take after disable");
    a_sei_defers: assert property (boundary_i && op_i == CIV_OP_SEI
        |-> ##1 !stack_o.push)
        else $error("take at enable boundary");
    a_return_from_handler_op_pops: assert property (boundary_i && op_i == CIV_OP_RETURN_FROM_HANDLER_OP &&
        !in_entry_o |-> ##1 (stack_o.pop && !stack_o.push))
        else $error("return did not pop");
    a_reset_vec: assert property (reset_vec_o ==
        (reset_vector_boot_fuse_i ? BOOT_START : 15'h0000))
        else $error("wrong reset vector");
endmodule

bind civ_ctrl civ_ctrl_props #(.NSRC(NSRC), .BOOT_START(BOOT_START)) u_props (
    .clk_i, .rst_b_i, .boundary_i, .op_i, .vector_table_select_i,
    .reset_vector_boot_fuse_i, .pc_i, .ret_pc_i, .flags_o, .status_reg_o,
    .sp_o, .reset_vec_o, .stack_o, .pc_load_o, .pc_load_val_o,
    .active_src_o, .in_entry_o
);

// File: tb/test_cpu_interrupt_vectoring.sv
// Self-checking bench for the interrupt vectoring control
`timescale 1ns/1ps
module test_cpu_interrupt_vectoring;
    import civ_pkg::*;
    logic        clk_i, rst_b_i, boundary_i, status_reg_wr_i, sleeping_i, stall_o;
    logic        vector_table_select_i, reset_vector_boot_fuse_i, pc_load_o;
    logic        app_section_lock_bit_i, boot_section_lock_bit_i, in_entry_o;
    logic [7:0]  event_i, level_i, is_level_i, src_enable_i, flag_wr_i;
    logic [7:0]  flag_wdata_i, status_reg_wdata_i, flags_o, status_reg_o;
    logic [14:0] pc_i, ret_pc_i, reset_vec_o, pc_load_val_o, vec;
    logic [15:0] sp_o;
    logic [2:0]  active_src_o;
    civ_op_t     op_i;
    civ_stack_t  stack_o;
    int          err_total, checks, cyc, tpush, tload, ttake;

    civ_ctrl uut (
        .clk_i, .rst_b_i, .event_i, .level_i, .is_level_i, .src_enable_i,
        .flag_wr_i, .flag_wdata_i, .status_reg_wr_i, .status_reg_wdata_i, .boundary_i,
        .op_i, .sleeping_i, .vector_table_select_i, .reset_vector_boot_fuse_i,
        .app_section_lock_bit_i, .boot_section_lock_bit_i, .pc_i, .ret_pc_i,
        .flags_o, .status_reg_o, .sp_o, .reset_vec_o, .stall_o, .stack_o,
        .pc_load_o, .pc_load_val_o, .active_src_o, .in_entry_o
    );
    civ_cpu_model u_cpu (
        .clk_i, .rst_b_i, .boundary_i, .stall_i(stall_o), .stack_i(stack_o),
        .pc_load_i(pc_load_o), .pc_load_val_i(pc_load_val_o), .pc_o(pc_i),
        .ret_pc_o(ret_pc_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (stack_o.push === 1'b1)
            tpush = cyc;
        if (pc_load_o === 1'b1) begin
            tload = cyc;
            vec = pc_load_val_o;
        end
    end

    task chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task step;
        @(posedge clk_i);
        #1;
    endtask

    task poke(input logic [7:0] sr, ev, fw, fd, input logic sw);
        step;
        {status_reg_wr_i, status_reg_wdata_i, event_i, flag_wr_i} = {sw, sr, ev, fw};
        flag_wdata_i = fd;
        step;
        {status_reg_wr_i, event_i, flag_wr_i} = '0;
    endtask

    // Waits out any entry or return first, as the sequencer would stall
    task instr(input civ_op_t op, input int len);
        step;
        for (int n = 0; n < 40 && in_entry_o !== 1'b0; n++)
            step;
        repeat (len - 1) step;
        boundary_i = 1'b1;
        op_i = op;
        step;
        ttake = cyc;
        boundary_i = 1'b0;
        op_i = CIV_OP_NONE;
    endtask

    task take(input logic [2:0] s, input logic [14:0] v, input int d);
        repeat (d + 2) step;
        chk("entry", tpush - ttake, d);
        chk("load", tload - tpush, 2);
        chk("vector", vec, v);
        chk("source", active_src_o, s);
        chk("gie", status_reg_o[7], 1'b0);
    endtask

    task none;
        repeat (6) step;
        chk("no_take", tpush > ttake, 1'b0);
    endtask

    task t_reset;
        chk("flags", flags_o, 8'h00);
        chk("status", {status_reg_o, sp_o}, 24'h00_0000);
        chk("rvec", reset_vec_o, 15'h0000);
        reset_vector_boot_fuse_i = 1'b1;
        #1;
        chk("rvec", reset_vec_o, 15'h7000);
        reset_vector_boot_fuse_i = 1'b0;
    endtask

    task t_pending;
        poke(8'h15, 8'h28, 8'h00, 8'h00, 1'b1);
        chk("flags", flags_o, 8'h28);
        instr(CIV_OP_NONE, 1);
        none;
        src_enable_i = 8'hFF;
        instr(CIV_OP_SEI, 1);
        none;
        instr(CIV_OP_NONE, 1);
        none;
        instr(CIV_OP_NONE, 3);
        take(3'h3, 15'h0008, 1);
        chk("flags", flags_o, 8'h20);
        chk("status", status_reg_o, 8'h15);
        chk("sp", sp_o, 16'hFFFE);
        chk("ret", ret_pc_i, 15'h0003);
    endtask

    task t_return;
        vector_table_select_i = 1'b1;
        instr(CIV_OP_RETURN_FROM_HANDLER_OP, 1);
        repeat (3) step;
        chk("ret_vec", vec, 15'h0003);
        chk("status", status_reg_o, 8'h95);
        chk("sp", sp_o, 16'h0000);
        instr(CIV_OP_NONE, 1);
        none;
        instr(CIV_OP_NONE, 1);
        take(3'h5, 15'h700C, 1);
        vector_table_select_i = 1'b0;
    endtask

    task t_clear;
        poke(8'h00, 8'h03, 8'h00, 8'h00, 1'b0);
        poke(8'h00, 8'h00, 8'hFF, 8'h01, 1'b0);
        chk("flags", flags_o, 8'h02);
        poke(8'h00, 8'h00, 8'hFF, 8'h00, 1'b0);
        chk("flags", flags_o, 8'h02);
        poke(8'h00, 8'h00, 8'h02, 8'h02, 1'b0);
        chk("flags", flags_o, 8'h00);
    endtask

    task t_cli;
        poke(8'h80, 8'h04, 8'h00, 8'h00, 1'b1);
        instr(CIV_OP_CLI, 1);
        none;
        chk("gie", status_reg_o[7], 1'b0);
        instr(CIV_OP_NONE, 1);
        none;
        poke(8'h00, 8'h00, 8'h04, 8'h04, 1'b0);
    endtask

    task t_level;
        is_level_i = 8'h40;
        level_i = 8'h40;
        instr(CIV_OP_NONE, 1);
        none;
        level_i = 8'h00;
        poke(8'h80, 8'h00, 8'h00, 8'h00, 1'b1);
        instr(CIV_OP_NONE, 1);
        none;
        level_i = 8'h40;
        sleeping_i = 1'b1;
        instr(CIV_OP_NONE, 1);
        take(3'h6, 15'h000E, 5);
        {sleeping_i, level_i} = '0;
    endtask

    task t_lock;
        app_section_lock_bit_i = 1'b1;
        poke(8'h80, 8'h01, 8'h00, 8'h00, 1'b1);
        instr(CIV_OP_NONE, 1);
        none;
        app_section_lock_bit_i = 1'b0;
        instr(CIV_OP_NONE, 1);
        take(3'h0, 15'h0002, 1);
    endtask

    task give_verdict;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {rst_b_i, boundary_i, status_reg_wr_i, sleeping_i, vector_table_select_i} = '0;
        {reset_vector_boot_fuse_i, app_section_lock_bit_i} = '0;
        {event_i, level_i, is_level_i, src_enable_i, flag_wr_i} = '0;
        {flag_wdata_i, status_reg_wdata_i, boot_section_lock_bit_i} = '0;
        op_i = CIV_OP_NONE;
        repeat (20) step;
        rst_b_i = 1'b1;
        t_reset;
        t_pending;
        t_return;
        t_clear;
        t_cli;
        t_level;
        t_lock;
        give_verdict;
    end

    // Scenarios need under two hundred cycles; this allows about 4000
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
endmodule
